// ### dv/dcd_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// Port checker
// ----
module dcd_decoder_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire dcd_pkg::dcd_hreq_t hreq,
	input wire logic frame_start,
	input wire logic line_start,
	input wire logic [15:0] scan_line,
	input wire dcd_pkg::dcd_cfg_t cfg,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire logic burst_active,
	input wire logic soft_reset_done
);
	logic rd_req; // Read word taken this edge
	logic nop_req; // No-operation address word
	assign rd_req = hreq.valid && hreq.kind == dcd_pkg::DCD_K_READ;
	assign nop_req = hreq.valid && hreq.kind == dcd_pkg::DCD_K_CMD && hreq.data == 16'h0000;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Read of one code, any index
	sequence s_read(logic [7:0] code);
		rd_req && hreq.data[15:8] == code;
	endsequence

	chk_read_answer: assert property (rd_req |=> rd_valid)
		else $error("read word got no answer");
	chk_no_stray: assert property (rd_valid |-> $past(rd_req))
		else $error("answer without a read");
	chk_upper_zero: assert property (rd_valid |-> rd_data[15:8] == 8'h00)
		else $error("read upper byte not zero");
	chk_scan_high: assert property (s_read(8'h45) ##0 hreq.data[7:0] == 8'h00
		|=> rd_data == {8'h00, $past(scan_line[15:8])})
		else $error("scan line high byte wrong");
	chk_coeff_high: assert property (s_read(8'h66) |=> rd_data == {8'h00, $past(cfg.sensor_coeff[15:8])})
		else $error("coefficient high byte wrong");
	chk_frame_hold: assert property (!$stable(cfg.brightness) |-> $past(frame_start) || soft_reset_done)
		else $error("frame value moved off frame");
	chk_memory_access_control_cmd_low: assert property (!$stable(cfg.mem_access[4:0]) |-> $past(frame_start) || soft_reset_done)
		else $error("access low bits moved off frame");
	chk_line_reset: assert property (soft_reset_done && !$past(cfg.sleep) |-> $past(line_start))
		else $error("awake soft reset off line");
	chk_reset_values: assert property (soft_reset_done |-> cfg.sleep && cfg.pixel_format == 8'h77
		&& cfg.tear_line == 16'h0000)
		else $error("soft reset values wrong");
	chk_nop_burst: assert property (nop_req |=> !burst_active)
		else $error("burst survived no-operation");
	chk_standby_bits: assert property (cfg.deep_standby[7:1] == 7'h00)
		else $error("standby spare bits set");
endmodule : dcd_decoder_chk

bind dcd_decoder dcd_decoder_chk i_dcd_decoder_chk (.clk(clk), .resetn(resetn), .hreq(hreq),
	.frame_start(frame_start), .line_start(line_start), .scan_line(scan_line), .cfg(cfg),
	.rd_valid(rd_valid), .rd_data(rd_data), .burst_active(burst_active), .soft_reset_done(soft_reset_done));

`default_nettype wire

// ### dv/dcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// Host processor model
// ----
module dcd_host_model (
	input wire logic clk,
	output dcd_pkg::dcd_hreq_t hreq
);
	// Bus idle from time zero
	initial hreq = '0;

	// One word per cycle, launched on the falling edge so the rising edge sees it settled
	task automatic word(input dcd_pkg::dcd_kind_t k, input logic [15:0] d, input logic last, input logic brk);
		@(negedge clk);
		hreq <= {1'b1, k, last, brk, d};
	endtask : word
	task automatic idle();
		@(negedge clk);
		hreq <= '0;
	endtask : idle
	task automatic cmd(input logic [15:0] d);
		word(dcd_pkg::DCD_K_CMD, d, 1'b0, 1'b0);
	endtask : cmd
	task automatic par(input logic [15:0] d, input logic last);
		word(dcd_pkg::DCD_K_PARAM, d, last, 1'b0);
	endtask : par
	task automatic rq(input logic [15:0] d);
		word(dcd_pkg::DCD_K_READ, d, 1'b0, 1'b0);
	endtask : rq
	// Broken transfer: the staged bytes must be dropped
	task automatic abort();
		word(dcd_pkg::DCD_K_PARAM, 16'h0000, 1'b0, 1'b1);
	endtask : abort
	// Address with index, then one byte with the upper data byte zero
	task automatic wr(input logic [15:0] a, input logic [7:0] p);
		cmd(a);
		par({8'h00, p}, 1'b0);
	endtask : wr
	// Parameterless command; the MDDI link wants a zero dummy word after it
	task automatic bare(input logic [15:0] a, input logic mddi);
		cmd(a);
		if (mddi) begin
			par(16'h0000, 1'b0);
		end
	endtask : bare
endmodule : dcd_host_model

`default_nettype wire

// ### dv/tb_dcd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dcd_decoder;
	// ----
	// Signals
	// ----
	logic clk;
	logic resetn;
	dcd_pkg::dcd_link_t link_mode;
	dcd_pkg::dcd_hreq_t hreq;
	logic frame_start;
	logic line_start;
	logic [15:0] scan_line;
	dcd_pkg::dcd_coords_t coords;
	logic [7:0] chk_first;
	logic [7:0] chk_cont;
	dcd_pkg::dcd_cfg_t cfg;
	dcd_pkg::dcd_cfg_t cfg_keep; // Snapshot for the ignored code
	logic rd_valid;
	logic [15:0] rd_data;
	logic burst_active;
	logic soft_reset_done;
	int fails;
	int n_compared;

	dcd_decoder i_dcd_decoder (.clk(clk), .resetn(resetn), .link_mode(link_mode), .hreq(hreq),
		.frame_start(frame_start), .line_start(line_start), .scan_line(scan_line), .coords(coords),
		.chk_first(chk_first), .chk_cont(chk_cont), .cfg(cfg), .rd_valid(rd_valid), .rd_data(rd_data),
		.burst_active(burst_active), .soft_reset_done(soft_reset_done));
	dcd_host_model i_dcd_host_model (.clk(clk), .hreq(hreq));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----
	// Helpers
	// ----
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle frame (fr=1) or line pulse, then let the applying edge pass
	task automatic pulse(input logic fr);
		@(negedge clk);
		frame_start <= fr;
		line_start <= !fr;
		@(negedge clk);
		frame_start <= 1'b0;
		line_start <= 1'b0;
		tick(2);
	endtask : pulse
	// Read word; the answer lands one edge after it is taken
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		i_dcd_host_model.rq(a);
		i_dcd_host_model.idle();
		chk(16'(rd_valid), 16'h0001);
		tick(1);
		chk(16'(rd_valid), 16'h0000);
		chk(rd_data, exp);
	endtask : rd
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// ----
	// Scenarios
	// ----
	task automatic t_direct();
		chk(16'(cfg.pixel_format), 16'h0077);
		i_dcd_host_model.cmd(16'h3a00);
		i_dcd_host_model.par(16'hab55, 1'b0);
		i_dcd_host_model.idle();
		tick(1);
		chk(16'(cfg.pixel_format), 16'h0055);
	endtask : t_direct
	// Second write before the frame must win; standby keeps bit 0 only
	task automatic t_frame();
		i_dcd_host_model.wr(16'h5100, 8'h11);
		i_dcd_host_model.wr(16'h5100, 8'h22);
		i_dcd_host_model.wr(16'h4f00, 8'hff);
		i_dcd_host_model.idle();
		tick(2);
		chk(16'(cfg.brightness), 16'h0000);
		pulse(1'b1);
		chk(16'(cfg.brightness), 16'h0022);
		chk(16'(cfg.deep_standby), 16'h0001);
	endtask : t_frame
	task automatic t_group();
		i_dcd_host_model.wr(16'h2a00, 8'h12);
		i_dcd_host_model.wr(16'h2a01, 8'h34);
		i_dcd_host_model.wr(16'h2a02, 8'h56);
		i_dcd_host_model.idle();
		tick(1);
		chk(cfg.col_start, 16'h0000);
		i_dcd_host_model.wr(16'h2a03, 8'h78);
		i_dcd_host_model.idle();
		tick(1);
		chk(cfg.col_start, 16'h1234);
		chk(cfg.col_end, 16'h5678);
	endtask : t_group
	task automatic t_memory_access_control_cmd();
		i_dcd_host_model.wr(16'h3600, 8'hff);
		i_dcd_host_model.idle();
		tick(1);
		chk(16'(cfg.mem_access), 16'h00e0);
		pulse(1'b1);
		chk(16'(cfg.mem_access), 16'h00ff);
	endtask : t_memory_access_control_cmd
	// Packet link: a broken transfer stores nothing, a whole one commits
	task automatic t_packet();
		@(negedge clk) link_mode <= dcd_pkg::DCD_LINK_PACKET;
		i_dcd_host_model.cmd(16'h0044);
		repeat (31) i_dcd_host_model.par(16'h0099, 1'b0);
		i_dcd_host_model.abort();
		i_dcd_host_model.idle();
		pulse(1'b1);
		chk(cfg.tear_line, 16'h0000);
		i_dcd_host_model.cmd(16'h0044);
		i_dcd_host_model.par(16'h0012, 1'b0);
		i_dcd_host_model.par(16'h0034, 1'b1);
		i_dcd_host_model.idle();
		pulse(1'b1);
		chk(cfg.tear_line, 16'h1234);
		@(negedge clk) link_mode <= dcd_pkg::DCD_LINK_PARALLEL;
	endtask : t_packet
	task automatic t_reads();
		rd(16'h4500, 16'h00be);
		rd(16'h4501, 16'h0037);
		i_dcd_host_model.wr(16'h6500, 8'ha1);
		i_dcd_host_model.wr(16'h6501, 8'hb2);
		i_dcd_host_model.idle();
		pulse(1'b1);
		rd(16'h6600, 16'h00a1);
		rd(16'h6700, 16'h00b2);
		rd(16'h7000, 16'h00ed);
		rd(16'h7100, 16'h00a3);
		rd(16'h7400, 16'h0099);
		rd(16'haa00, 16'h005a);
		rd(16'haf00, 16'h00c3);
		rd(16'h9900, 16'h0000);
	endtask : t_reads
	// Minimum brightness reads back before the frame applies it
	task automatic t_min();
		i_dcd_host_model.wr(16'h5e00, 8'h42);
		i_dcd_host_model.idle();
		rd(16'h5f00, 16'h0042);
		chk(16'(cfg.min_bright), 16'h0000);
		pulse(1'b1);
		chk(16'(cfg.min_bright), 16'h0042);
	endtask : t_min
	task automatic t_ignore();
		cfg_keep = cfg;
		i_dcd_host_model.wr(16'h9900, 8'h77);
		i_dcd_host_model.idle();
		tick(2);
		n_compared++;
		if (cfg !== cfg_keep) begin
			fails++;
			$display("mismatch at %0t: unknown code changed state", $time);
		end
	endtask : t_ignore
	task automatic t_burst();
		i_dcd_host_model.cmd(16'h2c00);
		i_dcd_host_model.idle();
		tick(1);
		chk(16'(burst_active), 16'h0001);
		i_dcd_host_model.cmd(16'h0000);
		i_dcd_host_model.idle();
		tick(1);
		chk(16'(burst_active), 16'h0000);
	endtask : t_burst
	// MDDI wake, then soft reset while awake waits for a line
	task automatic t_sleep();
		@(negedge clk) link_mode <= dcd_pkg::DCD_LINK_MDDI;
		i_dcd_host_model.bare(16'h1100, 1'b1);
		i_dcd_host_model.idle();
		tick(8);
		chk(16'(cfg.sleep), 16'h0000);
		i_dcd_host_model.bare(16'h0100, 1'b1);
		i_dcd_host_model.idle();
		tick(2);
		chk(16'(cfg.sleep), 16'h0000);
		pulse(1'b0);
		chk(16'(cfg.sleep), 16'h0001);
		chk(16'(cfg.pixel_format), 16'h0077);
		chk(16'(cfg.brightness), 16'h0000);
		tick(8);
		// Asleep again, so the next soft reset must apply at once, no line pulse given
		i_dcd_host_model.wr(16'h3a00, 8'h66);
		i_dcd_host_model.bare(16'h0100, 1'b1);
		i_dcd_host_model.idle();
		chk(16'(soft_reset_done), 16'h0001);
		tick(1);
		chk(16'(cfg.pixel_format), 16'h0077);
	endtask : t_sleep

	// Watchdog: a hang counts as a mismatch
	initial begin
		tick(20000);
		fails++;
		summarize();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		resetn = 1'b0;
		link_mode = dcd_pkg::DCD_LINK_PARALLEL;
		frame_start = 1'b0;
		line_start = 1'b0;
		scan_line = 16'hbe37;
		coords = '0;
		coords[0] = 10'h28f;
		coords[1] = 10'h152;
		coords[2] = 10'h133;
		coords[3] = 10'h265;
		chk_first = 8'h5a;
		chk_cont = 8'hc3;
		fails = 0;
		n_compared = 0;
		tick(16);
		resetn <= 1'b1;
		tick(1);
		t_direct();
		t_frame();
		t_group();
		t_memory_access_control_cmd();
		t_packet();
		t_reads();
		t_min();
		t_ignore();
		t_burst();
		t_sleep();
		summarize();
	end
endmodule : tb_dcd_decoder

`default_nettype wire

// ### rtl/dcd_consts.svh
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define DCD_C_NOP 8'h00
`define DCD_C_SOFT_RESET_CMD 8'h01
`define DCD_C_SLPIN 8'h10
`define DCD_C_SLPOUT 8'h11
`define DCD_C_COLSET 8'h2a
`define DCD_C_ROWSET 8'h2b
`define DCD_C_MEMWR 8'h2c
`define DCD_C_MEMRD 8'h2e
`define DCD_C_PARTAR 8'h30
`define DCD_C_MACC 8'h36
`define DCD_C_PIXFMT 8'h3a
`define DCD_C_MEMWRC 8'h3c
`define DCD_C_MEMRDC 8'h3e
`define DCD_C_TEARSET 8'h44
`define DCD_C_SCANGET 8'h45
`define DCD_C_DEEP_STANDBY_BIT 8'h4f
`define DCD_C_BRWR 8'h51
`define DCD_C_BRRD 8'h52
`define DCD_C_CTLWR 8'h53
`define DCD_C_CTLRD 8'h54
`define DCD_C_ABCWR 8'h55
`define DCD_C_ABCRD 8'h56
`define DCD_C_MINWR 8'h5e
`define DCD_C_MINRD 8'h5f
`define DCD_C_LSCWR 8'h65
`define DCD_C_LSCHI 8'h66
`define DCD_C_LSCLO 8'h67
`define DCD_C_LOW_BW 8'h70
`define DCD_C_LOW_RG 8'h75
`define DCD_C_LOW_BA 8'h7a
`define DCD_C_COORD_LAST 8'h7e
`define DCD_C_MACCRD 8'h0b
`define DCD_C_FMTRD 8'h0c
`define DCD_C_CHK1 8'haa
`define DCD_C_CHK2 8'haf

// ----------------------------------------
// Sizes, masks and reset values
// ----------------------------------------
`define DCD_PKT_DEPTH 32
`define DCD_IMM_BITS 8'he0
`define DCD_DEEP_STANDBY_BIT_MASK 8'h01
`define DCD_CTL_MASK 8'h3f
`define DCD_ABC_MASK 8'h03
`define DCD_DEF_BYTE 8'h00
`define DCD_DEF_WORD 16'h0000
`define DCD_DEF_FMT 8'h77

`endif

// ### rtl/dcd_decoder.sv
`include "dcd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dcd_decoder (
	input wire logic clk,
	input wire logic resetn,
	input wire dcd_pkg::dcd_link_t link_mode, // Active host interface
	input wire dcd_pkg::dcd_hreq_t hreq, // Host words from the interface front end
	input wire logic frame_start, // Pulse at start of each display frame
	input wire logic line_start, // Pulse at start of each display line
	input wire logic [15:0] scan_line, // Current display scan line
	input wire dcd_pkg::dcd_coords_t coords, // Colour characteristics
	input wire logic [7:0] chk_first, // First checksum from memory side
	input wire logic [7:0] chk_cont, // Continue checksum from memory side
	output dcd_pkg::dcd_cfg_t cfg, // Configuration now in force
	output logic rd_valid, // Read answer strobe
	output logic [15:0] rd_data, // Read answer, upper byte zero
	output logic burst_active, // Frame memory burst in progress
	output logic soft_reset_done // Pulse when soft reset takes effect
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Parameter bytes each known write command expects
	function automatic logic [7:0] dcd_param_count(input logic [7:0] c);
		logic [7:0] n;
		n = 8'h00;
		if (c == `DCD_C_COLSET || c == `DCD_C_ROWSET || c == `DCD_C_PARTAR) begin
			n = 8'h04;
		end else if (c == `DCD_C_TEARSET || c == `DCD_C_LSCWR) begin
			n = 8'h02;
		end else if (c == `DCD_C_MACC || c == `DCD_C_PIXFMT || c == `DCD_C_DEEP_STANDBY_BIT || c == `DCD_C_BRWR ||
			c == `DCD_C_CTLWR || c == `DCD_C_ABCWR || c == `DCD_C_MINWR) begin
			n = 8'h01;
		end
		return n;
	endfunction : dcd_param_count

	// When a write command takes effect
	function automatic dcd_pkg::dcd_timing_t dcd_timing(input logic [7:0] c);
		dcd_pkg::dcd_timing_t t;
		t = dcd_pkg::DCD_AT_NONE;
		if (c == `DCD_C_NOP || c == `DCD_C_SLPOUT || c == `DCD_C_COLSET || c == `DCD_C_ROWSET ||
			c == `DCD_C_PIXFMT || c == `DCD_C_MEMWR || c == `DCD_C_MEMRD || c == `DCD_C_MEMWRC ||
			c == `DCD_C_MEMRDC) begin
			t = dcd_pkg::DCD_AT_DIR;
		end else if (c == `DCD_C_SLPIN || c == `DCD_C_PARTAR || c == `DCD_C_TEARSET || c == `DCD_C_DEEP_STANDBY_BIT ||
			c == `DCD_C_BRWR || c == `DCD_C_CTLWR || c == `DCD_C_ABCWR || c == `DCD_C_MINWR ||
			c == `DCD_C_LSCWR) begin
			t = dcd_pkg::DCD_AT_FRAME;
		end else if (c == `DCD_C_SOFT_RESET_CMD) begin
			t = dcd_pkg::DCD_AT_LINE_COND;
		end else if (c == `DCD_C_MACC) begin
			t = dcd_pkg::DCD_AT_BITWISE;
		end
		return t;
	endfunction : dcd_timing

	// Shared low-bits byte of four coordinates, first one on top
	function automatic logic [7:0] dcd_low_bits(input dcd_pkg::dcd_coords_t cc, input int base);
		return {cc[base][1:0], cc[base+1][1:0], cc[base+2][1:0], cc[base+3][1:0]};
	endfunction : dcd_low_bits

	// Software reset image of every command register
	function automatic dcd_pkg::dcd_cfg_t dcd_defaults();
		dcd_pkg::dcd_cfg_t d;
		d = '0;
		d.sleep = 1'b1;
		d.pixel_format = `DCD_DEF_FMT;
		d.mem_access = `DCD_DEF_BYTE;
		d.tear_line = `DCD_DEF_WORD;
		d.brightness = `DCD_DEF_BYTE;
		return d;
	endfunction : dcd_defaults

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] cmd_r; // Command being collected
	logic [7:0] idx_r; // Next parameter index
	logic open_r; // Command awaiting parameters
	logic [7:0] buf_r [0:`DCD_PKT_DEPTH-1]; // Staged parameter bytes
	dcd_pkg::dcd_cfg_t live_r; // Values in force
	dcd_pkg::dcd_cfg_t shadow_r; // Values written, waiting for boundary
	logic frame_pend_r; // Shadow holds frame-synchronised change
	logic line_pend_r; // Soft reset waits for next line
	logic rd_valid_r;
	logic [15:0] rd_data_r;
	logic burst_r;
	logic swr_done_r;

	// ----------------------------------------
	// Decode of the current host word
	// ----------------------------------------
	logic is_pkt; // Packet interface selected
	logic cmd_evt; // Address word
	logic par_evt; // Parameter word
	logic rd_evt; // Read request
	logic [7:0] new_cmd; // Code carried by an address word
	logic [7:0] c_cmd; // Command that commits this cycle
	logic commit; // Command complete and known
	logic [7:0] p0; // First four parameters incl. this word
	logic [7:0] p1;
	logic [7:0] p2;
	logic [7:0] p3;
	logic [7:0] cnt; // Expected parameter count

	always_comb begin
		is_pkt = (link_mode == dcd_pkg::DCD_LINK_PACKET);
		cmd_evt = hreq.valid && hreq.kind == dcd_pkg::DCD_K_CMD;
		par_evt = hreq.valid && hreq.kind == dcd_pkg::DCD_K_PARAM && open_r;
		rd_evt = hreq.valid && hreq.kind == dcd_pkg::DCD_K_READ;
		// Code in the upper byte of a 16-bit address off-packet
		new_cmd = is_pkt ? hreq.data[7:0] : hreq.data[15:8];
		c_cmd = cmd_evt ? new_cmd : cmd_r;
		cnt = dcd_param_count(c_cmd);
		commit = 1'b0;
		if (cmd_evt) begin
			if (is_pkt) begin
				commit = hreq.last && !hreq.brk;
			end else begin
				// MDDI must wait for the dummy word
				commit = (cnt == 8'h00) && link_mode != dcd_pkg::DCD_LINK_MDDI;
			end
		end else if (par_evt) begin
			if (is_pkt) begin
				commit = hreq.last && !hreq.brk;
			end else if (cnt == 8'h00) begin
				commit = (link_mode == dcd_pkg::DCD_LINK_MDDI);
			end else begin
				// Groups latch only after the last sub-address
				commit = (idx_r == cnt - 8'h01);
			end
		end
		// Unmapped codes never reach the registers
		if (dcd_timing(c_cmd) == dcd_pkg::DCD_AT_NONE) begin
			commit = 1'b0;
		end
		// Merge the arriving byte over the staged ones; upper data bits ignored
		p0 = (par_evt && idx_r == 8'h00) ? hreq.data[7:0] : buf_r[0];
		p1 = (par_evt && idx_r == 8'h01) ? hreq.data[7:0] : buf_r[1];
		p2 = (par_evt && idx_r == 8'h02) ? hreq.data[7:0] : buf_r[2];
		p3 = (par_evt && idx_r == 8'h03) ? hreq.data[7:0] : buf_r[3];
	end

	// ----------------------------------------
	// Command and parameter capture
	// ----------------------------------------

	// Packet mode stages up to the buffer depth; later bytes are dropped until idx_r wraps at 256 and staging restarts at 0
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r <= `DCD_C_NOP;
			idx_r <= 8'h00;
			open_r <= 1'b0;
		end else if (hreq.valid && hreq.brk) begin
			// Broken transfer: the command closes; in packet mode the breaking word commits nothing
			open_r <= 1'b0;
		end else if (cmd_evt) begin
			cmd_r <= new_cmd;
			idx_r <= is_pkt ? 8'h00 : hreq.data[7:0];
			open_r <= !commit && !(is_pkt && hreq.last);
		end else if (par_evt) begin
			idx_r <= idx_r + 8'h01;
			open_r <= is_pkt ? !hreq.last : 1'b1;
		end
	end

	// Staging buffer has no reset; bytes staged by earlier transfers stay in place and are read by a later short command
	always_ff @(posedge clk) begin
		if (par_evt && idx_r < 8'(`DCD_PKT_DEPTH)) begin
			buf_r[idx_r[4:0]] <= hreq.data[7:0];
		end
	end

	// ----------------------------------------
	// Execution and synchronised apply
	// ----------------------------------------

	// Shadow always tracks what was written; live follows at the boundary unless a no-operation or burst start commits on that edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			live_r <= dcd_defaults();
			shadow_r <= dcd_defaults();
			frame_pend_r <= 1'b0;
			line_pend_r <= 1'b0;
			swr_done_r <= 1'b0;
		end else if (line_pend_r && line_start) begin
			// Soft reset deferred to the line boundary while awake
			live_r <= dcd_defaults();
			shadow_r <= dcd_defaults();
			frame_pend_r <= 1'b0;
			line_pend_r <= 1'b0;
			swr_done_r <= 1'b1;
		end else if (commit && c_cmd == `DCD_C_SOFT_RESET_CMD && live_r.sleep) begin
			// Asleep: soft reset takes effect at once
			live_r <= dcd_defaults();
			shadow_r <= dcd_defaults();
			frame_pend_r <= 1'b0;
			swr_done_r <= 1'b1;
		end else begin
			swr_done_r <= 1'b0;
			if (frame_pend_r && frame_start) begin
				// Whole shadow moves over; direct fields already agree
				live_r <= shadow_r;
				frame_pend_r <= 1'b0;
			end
			if (commit) begin
				case (c_cmd)
					`DCD_C_SOFT_RESET_CMD: begin
						line_pend_r <= 1'b1;
					end
					`DCD_C_SLPOUT: begin
						live_r.sleep <= 1'b0;
						shadow_r.sleep <= 1'b0;
					end
					`DCD_C_SLPIN: begin
						shadow_r.sleep <= 1'b1;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_PIXFMT: begin
						live_r.pixel_format <= p0;
						shadow_r.pixel_format <= p0;
					end
					`DCD_C_COLSET: begin
						live_r.col_start <= {p0, p1};
						live_r.col_end <= {p2, p3};
						shadow_r.col_start <= {p0, p1};
						shadow_r.col_end <= {p2, p3};
					end
					`DCD_C_ROWSET: begin
						live_r.row_start <= {p0, p1};
						live_r.row_end <= {p2, p3};
						shadow_r.row_start <= {p0, p1};
						shadow_r.row_end <= {p2, p3};
					end
					`DCD_C_MACC: begin
						// Orientation bits now, refresh order bits at frame
						live_r.mem_access <= (p0 & `DCD_IMM_BITS) | (live_r.mem_access & ~`DCD_IMM_BITS);
						shadow_r.mem_access <= p0;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_PARTAR: begin
						shadow_r.part_start <= {p0, p1};
						shadow_r.part_end <= {p2, p3};
						frame_pend_r <= 1'b1;
					end
					`DCD_C_TEARSET: begin
						shadow_r.tear_line <= {p0, p1};
						frame_pend_r <= 1'b1;
					end
					`DCD_C_DEEP_STANDBY_BIT: begin
						shadow_r.deep_standby <= p0 & `DCD_DEEP_STANDBY_BIT_MASK;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_BRWR: begin
						shadow_r.brightness <= p0;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_CTLWR: begin
						shadow_r.disp_ctrl <= p0 & `DCD_CTL_MASK;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_ABCWR: begin
						shadow_r.abc_mode <= p0 & `DCD_ABC_MASK;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_MINWR: begin
						shadow_r.min_bright <= p0;
						frame_pend_r <= 1'b1;
					end
					`DCD_C_LSCWR: begin
						shadow_r.sensor_coeff <= {p0, p1};
						frame_pend_r <= 1'b1;
					end
					default: begin
						// No-operation and burst starts hold live_r, undoing a frame apply in the same cycle
						live_r <= live_r;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Frame memory burst tracking
	// ----------------------------------------

	// Any address word not marked broken ends a burst; burst commands open a new one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			burst_r <= 1'b0;
		end else if (swr_done_r) begin
			burst_r <= 1'b0;
		end else if (commit) begin
			burst_r <= (c_cmd == `DCD_C_MEMWR || c_cmd == `DCD_C_MEMRD ||
				c_cmd == `DCD_C_MEMWRC || c_cmd == `DCD_C_MEMRDC);
		end else if (cmd_evt && !hreq.brk) begin
			burst_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read answers
	// ----------------------------------------

	// One answer per read word, one cycle later; unknown reads answer zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= `DCD_DEF_WORD;
		end else begin
			rd_valid_r <= rd_evt;
			if (rd_evt) begin
				// Upper byte of every answer stays zero
				rd_data_r[15:8] <= `DCD_DEF_BYTE;
				if (hreq.data[15:8] == `DCD_C_SCANGET) begin
					rd_data_r[7:0] <= (hreq.data[7:0] == 8'h00) ? scan_line[15:8] : scan_line[7:0];
				end else if (hreq.data[15:8] == `DCD_C_BRRD) begin
					rd_data_r[7:0] <= live_r.brightness;
				end else if (hreq.data[15:8] == `DCD_C_CTLRD) begin
					rd_data_r[7:0] <= live_r.disp_ctrl;
				end else if (hreq.data[15:8] == `DCD_C_ABCRD) begin
					rd_data_r[7:0] <= live_r.abc_mode;
				end else if (hreq.data[15:8] == `DCD_C_MINRD) begin
					// Shows the written value before the frame boundary
					rd_data_r[7:0] <= shadow_r.min_bright;
				end else if (hreq.data[15:8] == `DCD_C_LSCHI) begin
					rd_data_r[7:0] <= live_r.sensor_coeff[15:8];
				end else if (hreq.data[15:8] == `DCD_C_LSCLO) begin
					rd_data_r[7:0] <= live_r.sensor_coeff[7:0];
				end else if (hreq.data[15:8] == `DCD_C_MACCRD) begin
					rd_data_r[7:0] <= live_r.mem_access;
				end else if (hreq.data[15:8] == `DCD_C_FMTRD) begin
					rd_data_r[7:0] <= live_r.pixel_format;
				end else if (hreq.data[15:8] == `DCD_C_CHK1) begin
					rd_data_r[7:0] <= chk_first;
				end else if (hreq.data[15:8] == `DCD_C_CHK2) begin
					rd_data_r[7:0] <= chk_cont;
				end else if (hreq.data[15:8] == `DCD_C_LOW_BW) begin
					rd_data_r[7:0] <= dcd_low_bits(coords, 0);
				end else if (hreq.data[15:8] == `DCD_C_LOW_RG) begin
					rd_data_r[7:0] <= dcd_low_bits(coords, 4);
				end else if (hreq.data[15:8] == `DCD_C_LOW_BA) begin
					rd_data_r[7:0] <= dcd_low_bits(coords, 8);
				end else if (hreq.data[15:8] > `DCD_C_LOW_BW && hreq.data[15:8] <= `DCD_C_COORD_LAST) begin
					// Upper eight bits; the top bit weighs one half
					rd_data_r[7:0] <= coords[4'(dcd_coord_idx(hreq.data[15:8]))][9:2];
				end else begin
					rd_data_r[7:0] <= `DCD_DEF_BYTE;
				end
			end
		end
	end

	// Coordinate slot for an upper-bits read code, skipping the low-bit codes
	function automatic logic [7:0] dcd_coord_idx(input logic [7:0] c);
		logic [7:0] k;
		k = c - `DCD_C_LOW_BW - 8'h01;
		if (c > `DCD_C_LOW_BA) begin
			k = k - 8'h02;
		end else if (c > `DCD_C_LOW_RG) begin
			k = k - 8'h01;
		end
		return k;
	endfunction : dcd_coord_idx

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cfg = live_r;
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;
	assign burst_active = burst_r;
	assign soft_reset_done = swr_done_r;

endmodule : dcd_decoder

`default_nettype wire

// ### rtl/dcd_pkg.sv
package dcd_pkg;

	// ----------------------------------------
	// Host transfer carrier
	// ----------------------------------------
	typedef enum logic [1:0] {DCD_K_IDLE, DCD_K_CMD, DCD_K_PARAM, DCD_K_READ} dcd_kind_t;

	typedef struct packed {
		logic valid; // Word present this cycle
		dcd_kind_t kind; // Address, parameter or read
		logic last; // Packet mode: final word of packet
		logic brk; // Packet mode: transfer broken
		logic [15:0] data; // Address or parameter word
	} dcd_hreq_t;

	typedef enum logic [1:0] {DCD_LINK_PACKET, DCD_LINK_PARALLEL, DCD_LINK_MDDI} dcd_link_t;

	typedef enum logic [2:0] {DCD_AT_NONE, DCD_AT_DIR, DCD_AT_FRAME, DCD_AT_LINE_COND, DCD_AT_BITWISE} dcd_timing_t;

	// ----------------------------------------
	// Applied configuration
	// ----------------------------------------
	typedef struct packed {
		logic sleep; // Sleep state
		logic [7:0] pixel_format;
		logic [7:0] mem_access;
		logic [15:0] col_start;
		logic [15:0] col_end;
		logic [15:0] row_start;
		logic [15:0] row_end;
		logic [15:0] part_start;
		logic [15:0] part_end;
		logic [15:0] tear_line;
		logic [7:0] deep_standby;
		logic [7:0] brightness;
		logic [7:0] disp_ctrl;
		logic [7:0] abc_mode;
		logic [7:0] min_bright;
		logic [15:0] sensor_coeff;
	} dcd_cfg_t;

	// Twelve 10-bit colour coordinates: Bkx Bky Wx Wy Rx Ry Gx Gy Bx By Ax Ay
	typedef logic [11:0][9:0] dcd_coords_t;

endpackage : dcd_pkg
